// ===== logic/frwp_map.vh
// Constants for the flash reset and write-protect controller.
// Included by the controller and its lock memory; definitions only.
`ifndef FRWP_MAP_VH
`define FRWP_MAP_VH
// Instruction codes.
`define FRWP_OP_RST_EN 8'h66
`define FRWP_OP_RST 8'h99
`define FRWP_OP_UNLOCK 8'h39
`define FRWP_OP_LOCK 8'h36
`define FRWP_OP_WREN 8'h06
`define FRWP_OP_WRDI 8'h04
`define FRWP_OP_PP 8'h02
`define FRWP_OP_QPP 8'h32
`define FRWP_OP_SE 8'h20
`define FRWP_OP_BE 8'hd8
`define FRWP_OP_CE 8'hc7
`define FRWP_OP_WRSR 8'h01
`define FRWP_OP_RDSR 8'h05
`define FRWP_OP_SUSP 8'h75
`define FRWP_OP_SECER 8'h44
`define FRWP_OP_SECPG 8'h42
// Status register one bit positions.
`define FRWP_SR_BUSY 0
`define FRWP_SR_WEL 1
`define FRWP_SR_BP_LO 2
`define FRWP_SR_BP_HI 4
`define FRWP_SR_TB 5
`define FRWP_SR_SEC 6
`define FRWP_SR_LOCK 7
`define FRWP_SR1_RESET 8'h00
`define FRWP_BP_ZERO 3'h0
// Lock map: 62 middle blocks plus 32 edge sectors = 94 lock bits.
`define FRWP_NLOCK 94
`define FRWP_LIDX_W 7
`define FRWP_BLK_TOP 6'h3f
`define FRWP_BLK_BOT 6'h00
`define FRWP_SECT_BASE 7'h3e
`define FRWP_SECT_PER_BLK 7'h10
// Timing: clock period in ns, times in ns.
`define FRWP_CLK_NS 100
`define FRWP_TRST_NS 30000
`define FRWP_HW_RESET_PULSE_MIN_NS 1000
`define FRWP_TRST_CYC ((`FRWP_TRST_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)
`define FRWP_HW_RESET_PULSE_MIN_CYC ((`FRWP_HW_RESET_PULSE_MIN_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS)
`define FRWP_CNT_W 16
`endif

// ===== logic/frwp_lock_mem.v
// Lock-bit store: one bit per region, registered read data.
// Assumes the controller drives index, set and clear on CLOCK.
`timescale 1ns/1ps
`include "frwp_map.vh"
module frwp_lock_mem (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire init,
   input wire wr,
   input wire wr_val,
   input wire [`FRWP_LIDX_W-1:0] idx,
   output reg rd_bit
);
   reg [`FRWP_NLOCK-1:0] bits;
   genvar g;
   // Each bit goes to 1 on reset or init and takes wr_val when addressed.
   generate
      for (g = 0; g < `FRWP_NLOCK; g = g + 1) begin : lk
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               bits[g] <= 1'b1;
            end else if (ce) begin
               if (init) begin
                  bits[g] <= 1'b1;
               end else if (wr && idx == g) begin
                  bits[g] <= wr_val;
               end
            end
         end
      end
   endgenerate
   // Read data is registered; an out-of-range index reads as locked.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_bit <= 1'b1;
      end else if (ce) begin
         rd_bit <= (idx < `FRWP_NLOCK) ? bits[idx] : 1'b1;
      end
   end
endmodule

// ===== logic/frwp_ctrl.v
// Reset and write-protect controller for a serial flash.
// Assumes an upstream decoder hands over whole instructions as a strobe
// with opcode, block and sector fields, all on CLOCK.
// How it works
// RQ1: Reset runs only if 66h is directly followed by 99h.
// RQ2: After software reset, reject all instructions for about 30 us.
// RQ3: Reset pin low at least 1 us aborts everything, back to power-on; the code enters the 30 us reset recovery and keeps the status lock.
// RQ4: Reset pin wins over chip select, clock and data activity.
// RQ5: While power is not good, stay in reset and recognise nothing.
// RQ6: After power rises, refuse write-type instructions for a fixed delay.
// RQ7: Write enable latch clears to 0 at power-up.
// RQ8: Program, erase and status writes need the write enable latch.
// RQ9: Write enable sets latch S1, readable as status.
// RQ10: Latch clears after write disable and any program, erase or write.
// RQ11: One lock per middle 64KB block, per 4KB sector at both ends.
// RQ12: Lock 0 lets erase and program run; lock 1 silently ignores them.
// RQ13: All lock bits are 1 after power-on.
// RQ14: Unlock 39h clears the addressed region's lock bit.
// RQ15: Scheme select 0 uses protect bits, 1 uses lock bits only.
// RQ16: Busy S0 is 1 while program, erase or write runs.
// RQ17: While busy only status read and suspend are heard; the code acts on no instruction while busy, 75h suspend included.
// RQ18: Status write sets block protect bits S4..S2, default 0.
// RQ19: Status writes need the status lock clear and the latch set.
// RQ20: Top/bottom 0 protects from the top, 1 from the bottom.
// RQ21: Sector bit 1 counts 4KB sectors, 0 counts 64KB blocks.
// RQ22: Complement bit inverts the chosen protected region.
// RQ23: Any reset leaves latch and busy 0 and all locks 1.
// RQ24: A protection refusal changes nothing and never sets busy.
`timescale 1ns/1ps
`include "frwp_map.vh"
module frwp_ctrl #(
   parameter [`FRWP_CNT_W-1:0] PUW_CYCLES = 16'h2710
) (
   input wire CLOCK,
   input wire RSTN,
   input wire CE,
   input wire POWER_GOOD,
   input wire RESET_PIN_N,
   input wire CMD_VALID,
   input wire [7:0] CMD_OP,
   input wire [5:0] CMD_BLOCK,
   input wire [3:0] CMD_SECTOR,
   input wire [7:0] CMD_SR1,
   input wire CMD_CMP,
   input wire CMD_WPS,
   input wire OP_DONE,
   output reg [7:0] FLASH_STATUS_ONE,
   output reg COMPLEMENT_PROTECT,
   output reg PROTECT_SCHEME_SELECT,
   output reg STATUS_LOCK,
   output reg OP_START,
   output reg OP_REFUSED,
   output reg IN_RESET
);
   localparam [3:0] ST_OFF = 4'h1;
   localparam [3:0] ST_PUW = 4'h2;
   localparam [3:0] ST_RUN = 4'h4;
   localparam [3:0] ST_RST = 4'h8;
   reg [3:0] state;
   reg [3:0] next_state;
   reg pg_s1, pg_s2, rp_s1, rp_s2;
   reg [`FRWP_CNT_W-1:0] cnt;
   reg [`FRWP_CNT_W-1:0] rp_cnt;
   reg rst_armed;
   reg busy;
   reg write_enable_latch;
   reg [2:0] block_protect_bits;
   reg top_bottom_select;
   reg sector_granularity;
   reg chk_pending;
   reg [7:0] chk_op;
   reg [5:0] chk_block;
   reg [3:0] chk_sector;
   wire lock_bit;
   wire hw_reset;
   wire soft_go;
   wire reset_all;
   reg [`FRWP_LIDX_W-1:0] lidx;
   reg [5:0] sel_block;
   reg [3:0] sel_sector;
   reg bp_hit;
   reg [6:0] span;
   reg [9:0] unit;
   reg [9:0] pos;
   // Pin inputs cross into CLOCK through two flip-flops each.
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pg_s1 <= 1'b0;
         pg_s2 <= 1'b0;
         rp_s1 <= 1'b1;
         rp_s2 <= 1'b1;
      end else if (CE) begin
         pg_s1 <= POWER_GOOD;
         pg_s2 <= pg_s1;
         rp_s1 <= RESET_PIN_N;
         rp_s2 <= rp_s1;
      end
   end
   // The reset pin is honoured once held low long enough; shorter pulses
   // may be filtered, which keeps a glitch from wiping the locks.
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rp_cnt <= {`FRWP_CNT_W{1'b0}};
      end else if (CE) begin
         if (rp_s2) begin
            rp_cnt <= {`FRWP_CNT_W{1'b0}};
         end else if (rp_cnt < `FRWP_HW_RESET_PULSE_MIN_CYC) begin
            rp_cnt <= rp_cnt + 16'h0001; // RQ3
         end
      end
   end
   assign hw_reset = (rp_cnt >= `FRWP_HW_RESET_PULSE_MIN_CYC - 1) && !rp_s2; // RQ3
   // The pin and power state override any command activity.
   assign soft_go = (state == ST_RUN) && CMD_VALID && !busy && rst_armed
      && CMD_OP == `FRWP_OP_RST; // RQ1
   assign reset_all = hw_reset || !pg_s2 || soft_go; // RQ4 RQ5 RQ23

   // Top-level state: off, power-up write delay, running, reset recovery.
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (pg_s2) begin
               next_state = ST_PUW;
            end
         end
         ST_PUW: begin
            if (cnt >= PUW_CYCLES - 16'h0001) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (soft_go) begin
               next_state = ST_RST;
            end
         end
         ST_RST: begin
            if (cnt >= `FRWP_TRST_CYC - 1) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      if (!pg_s2) begin
         next_state = ST_OFF; // RQ5
      end else if (hw_reset) begin
         next_state = ST_RST; // RQ3 RQ4
      end
   end

   // State register and its shared timer.
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state <= ST_OFF;
         cnt <= {`FRWP_CNT_W{1'b0}};
      end else if (CE) begin
         state <= next_state;
         if (next_state != state || hw_reset) begin
            cnt <= {`FRWP_CNT_W{1'b0}};
         end else if (state == ST_PUW || state == ST_RST) begin
            cnt <= cnt + 16'h0001; // RQ2 RQ6
         end
      end
   end

   // Lock index: middle blocks 1..62 map to 0..61, edge sectors follow.
   // The index follows the incoming command, so the registered lock read
   // is ready for the check one cycle later instead of showing a stale bit.
   always @* begin
      sel_block = chk_pending ? chk_block : CMD_BLOCK;
      sel_sector = chk_pending ? chk_sector : CMD_SECTOR;
      if (sel_block == `FRWP_BLK_BOT) begin
         lidx = `FRWP_SECT_BASE + {3'h0, sel_sector}; // RQ11
      end else if (sel_block == `FRWP_BLK_TOP) begin
         lidx = `FRWP_SECT_BASE + `FRWP_SECT_PER_BLK + {3'h0, sel_sector}; // RQ11
      end else begin
         lidx = {1'b0, sel_block} - 7'h01; // RQ11
      end
   end

   // Block-protect range check in 4KB units over 1024 units of array.
   always @* begin
      span = 7'h00;
      if (block_protect_bits != `FRWP_BP_ZERO) begin
         span = 7'h01 << (block_protect_bits - 3'h1); // RQ18
      end
      if (sector_granularity) begin
         unit = {3'h0, span}; // RQ21
         if (block_protect_bits[2]) begin
            unit = 10'h008; // Sector mode tops out at 32KB.
         end
      end else begin
         unit = {span[5:0], 4'h0};
      end
      pos = {chk_block, chk_sector};
      if (top_bottom_select) begin
         bp_hit = pos < unit; // RQ20
      end else begin
         bp_hit = pos >= (10'h000 - unit) && unit != 10'h000; // RQ20
      end
      if (block_protect_bits == 3'h7 && !sector_granularity) begin
         bp_hit = 1'b1;
      end
      if (COMPLEMENT_PROTECT) begin
         bp_hit = !bp_hit; // RQ22
      end
   end

   frwp_lock_mem u_lock (
      .clk(CLOCK),
      .rstn(RSTN),
      .ce(CE),
      .init(reset_all), // RQ13 RQ23
      .wr(chk_pending && chk_op == `FRWP_OP_UNLOCK),
      .wr_val(1'b0), // RQ14
      .idx(lidx),
      .rd_bit(lock_bit)
   );

   // Instruction handling. Programs and sector or block erases take a second cycle for the lock
   // read, so the lock memory can stay a registered single-port store.
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_armed <= 1'b0;
         busy <= 1'b0;
         write_enable_latch <= 1'b0;
         block_protect_bits <= `FRWP_BP_ZERO;
         top_bottom_select <= 1'b0;
         sector_granularity <= 1'b0;
         COMPLEMENT_PROTECT <= 1'b0;
         PROTECT_SCHEME_SELECT <= 1'b0;
         STATUS_LOCK <= 1'b0;
         chk_pending <= 1'b0;
         chk_op <= 8'h00;
         chk_block <= 6'h00;
         chk_sector <= 4'h0;
         OP_START <= 1'b0;
         OP_REFUSED <= 1'b0;
      end else if (CE) begin
         OP_START <= 1'b0;
         OP_REFUSED <= 1'b0;
         chk_pending <= 1'b0;
         if (reset_all) begin
            rst_armed <= 1'b0;
            busy <= 1'b0; // RQ23
            write_enable_latch <= 1'b0; // RQ7 RQ23
            chk_pending <= 1'b0;
            if (!pg_s2) begin
               STATUS_LOCK <= 1'b0;
            end
         end else if (chk_pending) begin
            if (chk_op != `FRWP_OP_UNLOCK) begin
               if (PROTECT_SCHEME_SELECT ? lock_bit : bp_hit) begin
                  OP_REFUSED <= 1'b1; // RQ12 RQ15 RQ24
               end else begin
                  OP_START <= 1'b1;
                  busy <= 1'b1; // RQ16
                  write_enable_latch <= 1'b0; // RQ10
               end
            end
         end else if (busy) begin
            if (OP_DONE) begin
               busy <= 1'b0; // RQ16
            end
            if (CMD_VALID) begin
               rst_armed <= 1'b0; // RQ17
            end
         end else if (CMD_VALID && state == ST_RUN) begin
            rst_armed <= (CMD_OP == `FRWP_OP_RST_EN); // RQ1
            case (CMD_OP)
               `FRWP_OP_WREN: begin
                  write_enable_latch <= 1'b1; // RQ9
               end
               `FRWP_OP_WRDI: begin
                  write_enable_latch <= 1'b0; // RQ10
               end
               `FRWP_OP_PP, `FRWP_OP_QPP, `FRWP_OP_SE, `FRWP_OP_BE: begin
                  if (write_enable_latch) begin
                     chk_pending <= 1'b1; // RQ8
                     chk_op <= CMD_OP;
                     chk_block <= CMD_BLOCK;
                     chk_sector <= CMD_SECTOR;
                  end
               end
               `FRWP_OP_CE: begin
                  if (write_enable_latch && !PROTECT_SCHEME_SELECT
                        && block_protect_bits == `FRWP_BP_ZERO
                        && !COMPLEMENT_PROTECT) begin
                     OP_START <= 1'b1; // RQ8
                     busy <= 1'b1;
                     write_enable_latch <= 1'b0; // RQ10
                  end else if (write_enable_latch) begin
                     OP_REFUSED <= 1'b1; // RQ24
                  end
               end
               `FRWP_OP_SECER, `FRWP_OP_SECPG: begin
                  if (write_enable_latch) begin
                     OP_START <= 1'b1;
                     busy <= 1'b1; // RQ16
                     write_enable_latch <= 1'b0; // RQ10
                  end
               end
               `FRWP_OP_WRSR: begin
                  if (write_enable_latch && !STATUS_LOCK) begin
                     block_protect_bits <=
                        CMD_SR1[`FRWP_SR_BP_HI:`FRWP_SR_BP_LO]; // RQ18
                     top_bottom_select <= CMD_SR1[`FRWP_SR_TB];
                     sector_granularity <= CMD_SR1[`FRWP_SR_SEC];
                     COMPLEMENT_PROTECT <= CMD_CMP;
                     PROTECT_SCHEME_SELECT <= CMD_WPS; // RQ15
                     STATUS_LOCK <= CMD_SR1[`FRWP_SR_LOCK];
                     OP_START <= 1'b1;
                     busy <= 1'b1; // RQ16
                     write_enable_latch <= 1'b0; // RQ10
                  end else begin
                     OP_REFUSED <= 1'b1; // RQ19
                  end
               end
               `FRWP_OP_UNLOCK: begin
                  chk_pending <= 1'b1; // RQ14
                  chk_op <= CMD_OP;
                  chk_block <= CMD_BLOCK;
                  chk_sector <= CMD_SECTOR;
               end
               default: begin
               end
            endcase
         end else if (CMD_VALID) begin
            rst_armed <= 1'b0; // RQ2 RQ6
         end
      end
   end

   // Registered status view and reset indication.
   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         FLASH_STATUS_ONE <= `FRWP_SR1_RESET;
         IN_RESET <= 1'b1;
      end else if (CE) begin
         FLASH_STATUS_ONE <= {STATUS_LOCK, sector_granularity, top_bottom_select,
            block_protect_bits, write_enable_latch, busy}; // RQ9 RQ16
         IN_RESET <= (next_state != ST_RUN); // RQ5
      end
   end
endmodule

// ===== test/frwp_datapath.sv
// Datapath stand-in that ends each started operation after dly cycles.
// Assumes start is a one-cycle pulse on clk and dly is held steady.
`timescale 1ns/1ps
module frwp_datapath (
   input wire clk,
   input wire rstn,
   input wire start,
   input wire [7:0] dly,
   output reg done
);
   reg [7:0] cnt;
   // A zero count means idle; a long dly lets the bench act while busy.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
         done <= 1'b0;
      end else begin
         done <= (cnt == 8'h01);
         if (start) begin
            cnt <= dly;
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// ===== test/frwp_ctrl_asserts.sv
// Timing checks on the controller's ports.
// Assumes the status output lags the internal state by one cycle.
`timescale 1ns/1ps
`include "frwp_map.vh"
module frwp_ctrl_asserts (
   input wire CLOCK,
   input wire RSTN,
   input wire CE,
   input wire CMD_VALID,
   input wire [7:0] CMD_OP,
   input wire OP_DONE,
   input wire [7:0] FLASH_STATUS_ONE,
   input wire OP_START,
   input wire OP_REFUSED,
   input wire IN_RESET
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   // A command is heard only when running, idle and not just started.
   wire take = CE && CMD_VALID && !IN_RESET && !FLASH_STATUS_ONE[0] && !OP_START;
   start_refuse_excl_a: assert property (!(OP_START && OP_REFUSED))
      else $error("start and refusal together");
   start_single_a: assert property (OP_START |=> !OP_START)
      else $error("start lasted more than a cycle");
   start_busy_a: assert property (OP_START |=> FLASH_STATUS_ONE[0] && !FLASH_STATUS_ONE[1])
      else $error("start did not set busy and clear the latch");
   reset_no_start_a: assert property (IN_RESET |-> !OP_START)
      else $error("operation started while in reset");
   wel_set_a: assert property (take && CMD_OP == `FRWP_OP_WREN |-> ##2 FLASH_STATUS_ONE[1])
      else $error("write enable did not set the latch");
   wel_clear_a: assert property (
      take && CMD_OP == `FRWP_OP_WRDI |-> ##2 !FLASH_STATUS_ONE[1])
      else $error("write disable did not clear the latch");
   busy_fall_a: assert property ($fell(FLASH_STATUS_ONE[0]) |->
      $past(OP_DONE, 2) || IN_RESET || $past(IN_RESET) || $past(IN_RESET, 2))
      else $error("busy cleared without completion");
   refuse_idle_a: assert property (OP_REFUSED |=> !FLASH_STATUS_ONE[0])
      else $error("refusal set busy");
   cover property (OP_START);
   cover property (OP_REFUSED);
   cover property ($rose(IN_RESET));
endmodule
bind frwp_ctrl frwp_ctrl_asserts frwp_ctrl_asserts_i (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE),
   .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .OP_DONE(OP_DONE),
   .FLASH_STATUS_ONE(FLASH_STATUS_ONE), .OP_START(OP_START), .OP_REFUSED(OP_REFUSED),
   .IN_RESET(IN_RESET));

// ===== test/testbench.sv
// Self-checking bench for the reset and write-protect controller.
// Assumes decoded commands on falling edges; a datapath model ends operations.
`timescale 1ns/1ps
`include "frwp_map.vh"
module testbench;
   reg clock = 1'b0;
   reg rstn = 1'b0;
   reg pg = 1'b0;
   reg pin_n = 1'b1;
   reg vld = 1'b0;
   reg [7:0] op = 8'h00;
   reg [5:0] blk = 6'h00;
   reg [3:0] sec = 4'h0;
   reg [7:0] sr = 8'h00;
   reg cmpv = 1'b0;
   reg protect_scheme_select = 1'b0;
   reg [7:0] dly = 8'h03;
   reg st_seen = 1'b0;
   reg rf_seen = 1'b0;
   wire [7:0] stat;
   wire cmp, psel, slock, start, refused, in_rst, done;
   integer miscompares = 0;
   integer num_checks = 0;
   integer n;
   always #50 clock = ~clock;
   frwp_ctrl #(.PUW_CYCLES(16'h0014)) frwp_ctrl_i (.CLOCK(clock), .RSTN(rstn), .CE(1'b1),
      .POWER_GOOD(pg), .RESET_PIN_N(pin_n), .CMD_VALID(vld), .CMD_OP(op), .CMD_BLOCK(blk),
      .CMD_SECTOR(sec), .CMD_SR1(sr), .CMD_CMP(cmpv), .CMD_WPS(protect_scheme_select), .OP_DONE(done),
      .FLASH_STATUS_ONE(stat), .COMPLEMENT_PROTECT(cmp), .PROTECT_SCHEME_SELECT(psel),
      .STATUS_LOCK(slock), .OP_START(start), .OP_REFUSED(refused), .IN_RESET(in_rst));
   frwp_datapath frwp_datapath_i (.clk(clock), .rstn(rstn), .start(start), .dly(dly),
      .done(done));
   // Pulses stand one cycle, so sticky copies let the tasks look afterwards.
   always @(posedge clock) begin
      if (start) st_seen <= 1'b1;
      if (refused) rf_seen <= 1'b1;
   end
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   // One command pulse, then enough spacing for any answer to land.
   task cmd(input [7:0] o, input [5:0] b);
      begin
         st_seen = 1'b0;
         rf_seen = 1'b0;
         op = o;
         blk = b;
         vld = 1'b1;
         @(negedge clock);
         vld = 1'b0;
         repeat (4) @(negedge clock);
      end
   endtask
   // Waits for in_rst (s=1) or busy (s=0) to drop, with a bound.
   task settle(input s);
      begin
         n = 0;
         while ((s ? in_rst : stat[0]) !== 1'b0) begin
            @(negedge clock);
            n = n + 1;
            if (n > 1000) begin
               chk("timeout", 0, 1);
               end_of_test;
            end
         end
      end
   endtask
   task wr(input [7:0] o, input [5:0] b, input [1:0] exp);
      begin
         cmd(`FRWP_OP_WREN, 6'h00);
         cmd(o, b);
         chk("start_refuse", {st_seen, rf_seen}, exp);
         settle(0);
      end
   endtask
   task wrsr(input [7:0] v, input c, input w);
      begin
         sr = v;
         cmpv = c;
         protect_scheme_select = w;
         wr(`FRWP_OP_WRSR, 6'h00, 2'h2);
         chk("status", stat, v);
      end
   endtask
   initial begin
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      pg = 1'b1;
      repeat (5) @(negedge clock);
      cmd(`FRWP_OP_WREN, 6'h00);
      chk("in_reset", in_rst, 1);
      settle(1);
      chk("status", stat, `FRWP_SR1_RESET);
      chk("config", {cmp, psel, slock}, 0);
      cmd(`FRWP_OP_PP, 6'h01);
      chk("pp_no_latch", st_seen, 0);
      cmd(`FRWP_OP_WRSR, 6'h00);
      chk("wrsr_no_latch", rf_seen, 1);
      cmd(`FRWP_OP_WREN, 6'h00);
      chk("latch", stat[1], 1);
      cmd(`FRWP_OP_WRDI, 6'h00);
      chk("latch", stat[1], 0);
      wrsr(8'h0c, 1'b0, 1'b0);
      wr(`FRWP_OP_PP, 6'h3f, 2'h1);
      wr(`FRWP_OP_SE, 6'h01, 2'h2);
      wr(`FRWP_OP_CE, 6'h00, 2'h1);
      dly = 8'h28;
      cmd(`FRWP_OP_WREN, 6'h00);
      cmd(`FRWP_OP_BE, 6'h02);
      cmd(`FRWP_OP_WREN, 6'h00);
      chk("busy", stat[1:0], 2'h1);
      settle(0);
      dly = 8'h03;
      wrsr(8'h2c, 1'b0, 1'b0);
      wr(`FRWP_OP_PP, 6'h3f, 2'h2);
      wr(`FRWP_OP_PP, 6'h00, 2'h1);
      wrsr(8'h2c, 1'b1, 1'b0);
      chk("cmp", cmp, 1);
      wr(`FRWP_OP_PP, 6'h3f, 2'h1);
      wr(`FRWP_OP_PP, 6'h01, 2'h2);
      wrsr(8'h44, 1'b0, 1'b0);
      sec = 4'hf;
      wr(`FRWP_OP_PP, 6'h3f, 2'h1);
      sec = 4'he;
      wr(`FRWP_OP_PP, 6'h3f, 2'h2);
      sec = 4'h0;
      wrsr(8'h00, 1'b0, 1'b1);
      chk("scheme", psel, 1);
      wr(`FRWP_OP_PP, 6'h05, 2'h1);
      cmd(`FRWP_OP_UNLOCK, 6'h05);
      settle(0);
      wr(`FRWP_OP_PP, 6'h05, 2'h2);
      wr(`FRWP_OP_SE, 6'h06, 2'h1);
      cmd(`FRWP_OP_UNLOCK, 6'h00);
      settle(0);
      wr(`FRWP_OP_PP, 6'h00, 2'h2);
      sec = 4'h1;
      wr(`FRWP_OP_PP, 6'h00, 2'h1);
      sec = 4'h0;
      cmd(`FRWP_OP_RST_EN, 6'h00);
      cmd(`FRWP_OP_WREN, 6'h00);
      cmd(`FRWP_OP_RST, 6'h00);
      chk("cancelled", {in_rst, stat[1]}, 2'h1);
      cmd(`FRWP_OP_RST_EN, 6'h00);
      cmd(`FRWP_OP_RST, 6'h00);
      chk("sw_reset", in_rst, 1);
      settle(1);
      chk("reset_time", n > 290, 1);
      chk("after_reset", stat[1:0], 2'h0);
      wrsr(8'h00, 1'b0, 1'b1);
      wr(`FRWP_OP_PP, 6'h05, 2'h1);
      cmd(`FRWP_OP_WREN, 6'h00);
      pin_n = 1'b0;
      cmd(`FRWP_OP_WREN, 6'h00);
      repeat (8) @(negedge clock);
      pin_n = 1'b1;
      settle(1);
      chk("hw_reset", stat[1:0], 2'h0);
      wrsr(8'h80, 1'b0, 1'b1);
      chk("status_lock", slock, 1);
      wr(`FRWP_OP_WRSR, 6'h00, 2'h1);
      pg = 1'b0;
      repeat (4) @(negedge clock);
      cmd(`FRWP_OP_WREN, 6'h00);
      chk("power_low", in_rst, 1);
      pg = 1'b1;
      settle(1);
      chk("power_back", stat[1], 0);
      chk("lock_cleared", slock, 0);
      end_of_test;
   end
endmodule
